// File: hw/pwm7_channel.v
// One 7-bit PWM channel: up counter, duty match, extra pulse, double buffer.
// Assumes a one-cycle source tick and run/config held steady by the caller.
`timescale 1ns/1ps
`include "pwm7_defs.vh"

module pwm7_channel (
  input  wire       clk,
  input  wire       reset,
  input  wire       enable,
  input  wire       src_tick,
  input  wire       polarity,
  input  wire       buf_en,
  input  wire       duty_wr,
  input  wire [7:0] duty_wdata,
  output wire [7:0] duty_rd,
  output wire       pwm_out,
  output wire       irq_pulse,
  output wire [6:0] count,
  output wire       phase
);

  reg  [6:0] count_reg;
  reg        phase_reg;
  reg        matched_reg;
  reg        out_reg;
  reg        irq_reg;
  reg  [7:0] act_reg;
  reg  [7:0] buf_reg;
  wire [7:0] target;
  wire       hit;
  wire       ovf;

  // ----------------------------------------
  // Match and overflow
  // ----------------------------------------
  // Extra pulse moves the second-period match one count later
  assign target = {1'b0, act_reg[7:1]} + {7'h00, act_reg[0] & phase_reg};
  // Compare is continuous, so an unbuffered write equal to the count matches at once
  assign hit = enable & ~matched_reg & (target == {1'b0, count_reg});
  assign ovf = enable & src_tick & (count_reg == `COUNT_LAST);

  always @(posedge clk) begin
    if (reset) begin
      count_reg   <= 7'h00;
      phase_reg   <= 1'b0;
      matched_reg <= 1'b0;
      out_reg     <= 1'b0;
      irq_reg     <= 1'b0;
    end else if (!enable) begin
      count_reg   <= 7'h00;
      phase_reg   <= 1'b0;
      matched_reg <= 1'b0;
      out_reg     <= polarity;
      irq_reg     <= 1'b0;
    end else begin
      irq_reg <= ovf & phase_reg;
      if (ovf) begin
        count_reg   <= 7'h00;
        phase_reg   <= ~phase_reg;
        matched_reg <= 1'b0;
        out_reg     <= polarity;
      end else begin
        if (src_tick)
          count_reg <= count_reg + 7'h01;
        if (hit) begin
          matched_reg <= 1'b1;
          out_reg     <= ~polarity;
        end
      end
    end
  end

  // ----------------------------------------
  // Duty register and its buffer
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      act_reg <= `DUTY_RESET;
      buf_reg <= `DUTY_RESET;
    end else begin
      if (duty_wr)
        buf_reg <= duty_wdata;
      if (duty_wr && (!enable || !buf_en))
        act_reg <= duty_wdata;
      else if (ovf && phase_reg && buf_en)
        act_reg <= buf_reg;
    end
  end

  assign duty_rd   = buf_reg;
  assign pwm_out   = out_reg;
  assign irq_pulse = irq_reg;
  assign count     = count_reg;
  assign phase     = phase_reg;

endmodule // pwm7_channel

// File: hw/pwm7_defs.vh
// Offsets, field positions and reset values of the two-channel 7-bit PWM timer.
// Assumes byte address = 4 * register index on a 32-bit AXI4-Lite bus.
`ifndef PWM7_DEFS_VH
`define PWM7_DEFS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_MODE_A     8'h20
`define IDX_MODE_B     8'h21
`define IDX_PAIR_CTRL  8'h22
`define IDX_STATUS     8'h23
`define IDX_SYS_CTRL   8'h24
`define IDX_DUTY_A     8'h28
`define IDX_DUTY_B     8'h29

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MODE_CKS_LSB   0
`define MODE_CKS_MSB   2
`define MODE_EXT_BIT   3
`define MODE_POL_BIT   4
`define MODE_DBE_BIT   5
`define MODE_TCM_LSB   6
`define MODE_TCM_MSB   7
`define TCM_PWM        2'h2
`define PAIR_RUN_LSB   0
`define PAIR_CAS_BIT   2
`define PAIR_AND_BIT   3
`define SYS_DIV_BIT    0
`define SYS_SLOW_BIT   1

// ----------------------------------------
// Reset values, sizes and responses
// ----------------------------------------
`define MODE_RESET     8'h00
`define DUTY_RESET     8'hFF
`define PAIR_RESET     4'h0
`define SYS_RESET      2'h0
`define COUNT_LAST     7'h7F
`define GEAR_DIV_W     11
`define LOW_DIV_W      4
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// File: hw/timer_pwm7_top.v
// Two 7-bit PWM timer channels with prescaler and an AXI4-Lite register slave.
// Assumes one clock, synchronous high reset and a one-cycle low_speed_tick.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "pwm7_defs.vh"

module timer_pwm7_top #(
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              reset,
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output wire              awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output wire              wready,
  output wire [1:0]        bresp,
  output wire              bvalid,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output wire              arready,
  output wire [31:0]       rdata,
  output wire [1:0]        rresp,
  output wire              rvalid,
  input  wire              rready,
  input  wire              low_speed_tick,
  output wire              pulse_output_pin_a,
  output wire              pulse_output_pin_b,
  output wire              timer_interrupt_request_a,
  output wire              timer_interrupt_request_b
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg                   aw_hold_reg;
  reg  [ADDR_W-1:0]     aw_addr_reg;
  reg                   w_hold_reg;
  reg  [31:0]           w_data_reg;
  reg  [3:0]            w_strb_reg;
  reg                   bvalid_reg;
  reg  [1:0]            bresp_reg;
  reg                   rvalid_reg;
  reg  [1:0]            rresp_reg;
  reg  [31:0]           rdata_reg;
  reg  [31:0]           rdata_next;
  reg                   rhit_next;
  reg                   whit_next;
  reg  [7:0]            chan_a_mode_reg;
  reg  [7:0]            chan_b_mode_reg;
  reg  [3:0]            pair_control_reg;
  reg  [1:0]            system_control_reg;
  reg  [`GEAR_DIV_W-1:0] gear_div_reg;
  reg  [`LOW_DIV_W-1:0]  low_div_reg;
  reg                   pin_a_reg;
  reg                   pin_b_reg;
  wire                  do_write;
  wire                  wr_lane0;
  wire [7:0]            wr_idx;
  wire                  wr_idx_ok;
  wire [7:0]            rd_idx;
  wire                  rd_idx_ok;
  wire [15:0]           mode_bus;
  wire [1:0]            run_bits;
  wire [7:0]            gear_tick;
  wire                  low_tick_0;
  wire                  low_tick_1;
  wire                  low_tick_7;
  wire                  divider_select_bit;
  wire                  slow_mode;
  wire                  output_and_enable;
  wire                  cascade_select;
  wire [1:0]            enable_w;
  wire [1:0]            duty_wr_w;
  wire [15:0]           duty_rd_w;
  wire [1:0]            pwm_out_w;
  wire [1:0]            irq_w;
  wire [13:0]           count_w;
  wire [1:0]            phase_w;
  wire                  low_clk_sel;
  wire                  wr_mode_a;
  wire                  wr_mode_b;
  wire                  wr_pair_ctrl;
  wire                  wr_sys_ctrl;

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  // Sized constants keep the address check and divider steps width-exact
  localparam [ADDR_W-11:0]      UPPER_ZERO = {(ADDR_W-10){1'b0}};
  localparam [`GEAR_DIV_W-1:0]  GEAR_STEP  = {{(`GEAR_DIV_W-1){1'b0}}, 1'b1};
  localparam [`LOW_DIV_W-1:0]   LOW_STEP   = {{(`LOW_DIV_W-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // Address and data are latched apart, so they may arrive in either order
  assign awready  = ~aw_hold_reg & ~bvalid_reg;
  assign wready   = ~w_hold_reg & ~bvalid_reg;
  assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign bvalid   = bvalid_reg;
  assign bresp    = bresp_reg;

  always @(posedge clk) begin
    if (reset) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= whit_next ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign wr_idx    = aw_addr_reg[9:2];
  assign wr_idx_ok = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg[ADDR_W-1:10] == UPPER_ZERO);
  // Writable registers are at most eight bits wide, so only byte lane 0 stores
  assign wr_lane0  = do_write & w_strb_reg[0];

  always @* begin
    whit_next = 1'b0;
    if (wr_idx_ok) begin
      case (wr_idx)
        `IDX_MODE_A:    whit_next = 1'b1;
        `IDX_MODE_B:    whit_next = 1'b1;
        `IDX_PAIR_CTRL: whit_next = 1'b1;
        `IDX_STATUS:    whit_next = 1'b1;
        `IDX_SYS_CTRL:  whit_next = 1'b1;
        `IDX_DUTY_A:    whit_next = 1'b1;
        `IDX_DUTY_B:    whit_next = 1'b1;
        default:        whit_next = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign arready   = ~rvalid_reg;
  assign rvalid    = rvalid_reg;
  assign rdata     = rdata_reg;
  assign rresp     = rresp_reg;
  assign rd_idx    = araddr[9:2];
  assign rd_idx_ok = (araddr[1:0] == 2'h0) && (araddr[ADDR_W-1:10] == UPPER_ZERO);

  always @* begin
    rdata_next = 32'h00000000;
    rhit_next  = rd_idx_ok;
    case (rd_idx)
      `IDX_MODE_A:    rdata_next[7:0] = chan_a_mode_reg;
      `IDX_MODE_B:    rdata_next[7:0] = chan_b_mode_reg;
      `IDX_PAIR_CTRL: rdata_next[3:0] = pair_control_reg;
      `IDX_STATUS:    rdata_next[17:0] = {pin_b_reg, pin_a_reg, phase_w[1], count_w[13:7],
                                          phase_w[0], count_w[6:0]};
      `IDX_SYS_CTRL:  rdata_next[1:0] = system_control_reg;
      `IDX_DUTY_A:    rdata_next[7:0] = duty_rd_w[7:0];
      `IDX_DUTY_B:    rdata_next[7:0] = duty_rd_w[15:8];
      default:        rhit_next = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rhit_next ? `RESP_OKAY : `RESP_SLVERR;
      rdata_reg  <= rhit_next ? rdata_next : 32'h00000000;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      chan_a_mode_reg    <= `MODE_RESET;
      chan_b_mode_reg    <= `MODE_RESET;
      pair_control_reg   <= `PAIR_RESET;
      system_control_reg <= `SYS_RESET;
    end else begin
      if (wr_mode_a)
        chan_a_mode_reg <= w_data_reg[7:0];
      if (wr_mode_b)
        chan_b_mode_reg <= w_data_reg[7:0];
      if (wr_pair_ctrl)
        pair_control_reg <= w_data_reg[3:0];
      if (wr_sys_ctrl)
        system_control_reg <= w_data_reg[1:0];
    end
  end

  // Mode is frozen while its channel runs
  assign wr_mode_a    = wr_lane0 & wr_idx_ok & (wr_idx == `IDX_MODE_A) & ~run_bits[0];
  assign wr_mode_b    = wr_lane0 & wr_idx_ok & (wr_idx == `IDX_MODE_B) & ~run_bits[1];
  assign wr_pair_ctrl = wr_lane0 & wr_idx_ok & (wr_idx == `IDX_PAIR_CTRL);
  assign wr_sys_ctrl  = wr_lane0 & wr_idx_ok & (wr_idx == `IDX_SYS_CTRL);

  assign mode_bus           = {chan_b_mode_reg, chan_a_mode_reg};
  assign run_bits           = pair_control_reg[`PAIR_RUN_LSB+1:`PAIR_RUN_LSB];
  assign cascade_select     = pair_control_reg[`PAIR_CAS_BIT];
  assign output_and_enable  = pair_control_reg[`PAIR_AND_BIT];
  assign divider_select_bit = system_control_reg[`SYS_DIV_BIT];
  assign slow_mode          = system_control_reg[`SYS_SLOW_BIT];
  assign low_clk_sel        = divider_select_bit | slow_mode;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Free-running dividers keep the channels phase-locked to each other
  always @(posedge clk) begin
    if (reset) begin
      gear_div_reg <= {`GEAR_DIV_W{1'b0}};
      low_div_reg  <= {`LOW_DIV_W{1'b0}};
    end else begin
      gear_div_reg <= gear_div_reg + GEAR_STEP;
      if (low_speed_tick)
        low_div_reg <= low_div_reg + LOW_STEP;
    end
  end

  assign gear_tick[0] = &gear_div_reg[10:0];
  assign gear_tick[1] = &gear_div_reg[9:0];
  assign gear_tick[2] = &gear_div_reg[7:0];
  assign gear_tick[3] = &gear_div_reg[5:0];
  assign gear_tick[4] = &gear_div_reg[3:0];
  assign gear_tick[5] = &gear_div_reg[1:0];
  assign gear_tick[6] = gear_div_reg[0];
  assign gear_tick[7] = 1'b1;
  assign low_tick_0   = low_speed_tick & (&low_div_reg[3:0]);
  assign low_tick_1   = low_speed_tick & (&low_div_reg[2:0]);
  assign low_tick_7   = low_speed_tick & (&low_div_reg[1:0]);

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_chan
      wire [7:0] mode;
      wire       pwm_mode;
      reg        src_tick;
      assign mode     = mode_bus[8*i +: 8];
      assign pwm_mode = (mode[`MODE_TCM_MSB:`MODE_TCM_LSB] == `TCM_PWM) & ~cascade_select &
                        ~mode[`MODE_EXT_BIT];
      assign enable_w[i]  = run_bits[i] & pwm_mode;
      assign duty_wr_w[i] = wr_lane0 & wr_idx_ok &
                            (wr_idx == ((i == 0) ? `IDX_DUTY_A : `IDX_DUTY_B));

      // Slow mode leaves codes other than 000, 001 and 111 with no clock
      always @* begin
        case (mode[`MODE_CKS_MSB:`MODE_CKS_LSB])
          3'h0: src_tick = low_clk_sel ? low_tick_0 : gear_tick[0];
          3'h1: src_tick = low_clk_sel ? low_tick_1 : gear_tick[1];
          3'h2: src_tick = ~slow_mode & gear_tick[2];
          3'h3: src_tick = ~slow_mode & gear_tick[3];
          3'h4: src_tick = ~slow_mode & gear_tick[4];
          3'h5: src_tick = ~slow_mode & gear_tick[5];
          3'h6: src_tick = ~slow_mode & gear_tick[6];
          3'h7: src_tick = slow_mode ? low_tick_7 : gear_tick[7];
          default: src_tick = 1'b0;
        endcase
      end

      pwm7_channel u_chan (
        .clk        (clk),
        .reset      (reset),
        .enable     (enable_w[i]),
        .src_tick   (src_tick),
        .polarity   (mode[`MODE_POL_BIT]),
        .buf_en     (mode[`MODE_DBE_BIT]),
        .duty_wr    (duty_wr_w[i]),
        .duty_wdata (w_data_reg[7:0]),
        .duty_rd    (duty_rd_w[8*i +: 8]),
        .pwm_out    (pwm_out_w[i]),
        .irq_pulse  (irq_w[i]),
        .count      (count_w[7*i +: 7]),
        .phase      (phase_w[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // One extra flop keeps both pins aligned whether or not AND is on
  always @(posedge clk) begin
    if (reset) begin
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
    end else begin
      pin_a_reg <= output_and_enable ? (pwm_out_w[0] & pwm_out_w[1]) : pwm_out_w[0];
      pin_b_reg <= pwm_out_w[1];
    end
  end

  assign pulse_output_pin_a        = pin_a_reg;
  assign pulse_output_pin_b        = pin_b_reg;
  assign timer_interrupt_request_a = irq_w[0];
  assign timer_interrupt_request_b = irq_w[1];

endmodule // timer_pwm7_top

// File: verif/pwm7_monitor.sv
// Port checker for the two-channel PWM timer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module pwm7_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic pulse_output_pin_a,
  input wire logic pulse_output_pin_b,
  input wire logic timer_interrupt_request_a,
  input wire logic timer_interrupt_request_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Cycles since last request; starts saturated so the first one is legal
  logic [7:0] gap_a;
  logic [7:0] gap_b;
  always @(posedge clk) begin
    if (reset) begin
      gap_a <= 8'hFF;
      gap_b <= 8'hFF;
    end else begin
      gap_a <= timer_interrupt_request_a ? 8'h00 : ((gap_a == 8'hFF) ? gap_a : gap_a + 8'h01);
      gap_b <= timer_interrupt_request_b ? 8'h00 : ((gap_b == 8'hFF) ? gap_b : gap_b + 8'h01);
    end
  end

  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence

  reset_pins_a: assert property (disable iff (1'b0) reset ##1 reset |->
    !pulse_output_pin_a && !pulse_output_pin_b) else $error("pins not low in reset");
  irq_single_a: assert property (timer_interrupt_request_a |=> !timer_interrupt_request_a)
    else $error("interrupt longer than one cycle");
  irq_gap_a: assert property (timer_interrupt_request_a |-> gap_a == 8'hFF)
    else $error("channel A interrupt on odd overflow");
  irq_gap_b_a: assert property (timer_interrupt_request_b |-> gap_b == 8'hFF)
    else $error("channel B interrupt on odd overflow");
  wr_resp_a: assert property (wr_taken |-> ##[1:2] bvalid)
    else $error("write response missing");
  wr_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted during response");
  rd_resp_a: assert property (rd_taken |=> rvalid)
    else $error("read response missing");
  rd_block_a: assert property (rvalid |-> !arready)
    else $error("read accepted during response");
endmodule // pwm7_monitor

// File: verif/pwm_load.sv
// External load on one pulse output pin: measures the last high and low run.
// Assumes the pin is registered on clk; lengths are in clk cycles.
`timescale 1ns/1ps

module pwm_load (
  input  wire logic       clk,
  input  wire logic       pin,
  output logic      [8:0] high_len,
  output logic      [8:0] low_len
);
  logic [8:0] run_len;
  logic       last_lvl;

  initial begin
    run_len  = 9'h000;
    last_lvl = 1'b0;
    high_len = 9'h000;
    low_len  = 9'h000;
  end

  // Saturates so a stuck pin cannot wrap back to a plausible length
  always @(posedge clk) begin
    if (pin != last_lvl) begin
      if (last_lvl) high_len <= run_len;
      else low_len <= run_len;
      run_len <= 9'h001;
    end else if (run_len != 9'h1FF) begin
      run_len <= run_len + 9'h001;
    end
    last_lvl <= pin;
  end
endmodule // pwm_load

// File: verif/timer_pwm7_with_extra_pulse_tb_top.sv
// Self-checking bench for the two-channel PWM timer over AXI4-Lite.
// Assumes source code 7 (one count per clk) unless a test picks a slower source.
`timescale 1ns/1ps
`include "pwm7_defs.vh"

module timer_pwm7_with_extra_pulse_tb_top;
  logic        clk, reset, awvalid, wvalid, bready, arvalid, rready, low_speed_tick;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr, br;
  logic        awready, wready, bvalid, arready, rvalid, pin_a, pin_b, irq_a, irq_b;
  logic [8:0]  hi_a, lo_a, hi_b, lo_b;
  int          bad_count, samples_checked;

  timer_pwm7_top u_dut (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .low_speed_tick(low_speed_tick), .pulse_output_pin_a(pin_a),
    .pulse_output_pin_b(pin_b), .timer_interrupt_request_a(irq_a), .timer_interrupt_request_b(irq_b));
  pwm_load u_load_a (.clk(clk), .pin(pin_a), .high_len(hi_a), .low_len(lo_a));
  pwm_load u_load_b (.clk(clk), .pin(pin_b), .high_len(hi_b), .low_len(lo_b));

  always #20 clk = ~clk;
  always @(posedge clk) low_speed_tick <= ~low_speed_tick;

  function automatic logic [11:0] ad(input logic [7:0] i);
    ad = {2'b00, i, 2'b00};
  endfunction

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    begin
      samples_checked++;
      if (s !== e) begin
        bad_count++;
        $display("ERROR %s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  // Every access aligns itself to a rising edge, so callers may come from a negedge
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    begin
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      do begin
        @(negedge clk); ta = awvalid && awready; tw = wvalid && wready; tk = bvalid; br = bresp;
        @(posedge clk); if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0;
      end while (!tk);
    end
  endtask

  task rd(input logic [11:0] a);
    logic tk;
    begin
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1;
      do begin @(negedge clk); tk = arready; @(posedge clk); end while (!tk);
      arvalid <= 1'b0;
      do begin @(negedge clk); tk = rvalid; rv = rdata; rr = rresp; @(posedge clk); end while (!tk);
    end
  endtask

  task cn(input int n);
    repeat (n) @(negedge clk);
  endtask

  task wirq(input logic b);
    do @(negedge clk); while (!(b ? irq_b : irq_a));
  endtask

  task lens(input logic [8:0] lo, input logic [8:0] hi);
    begin
      chk("low_a", 32'(lo_a), 32'(lo));
      chk("high_a", 32'(hi_a), 32'(hi));
    end
  endtask

  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0; reset = 1'b1; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; low_speed_tick = 1'b0;
    bready = 1'b1; rready = 1'b1; wstrb = 4'hF; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0;
    bad_count = 0; samples_checked = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    // Reset state and an unmapped place
    rd(ad(`IDX_DUTY_A)); chk("duty_a", rv, 32'h000000FF);
    rd(ad(`IDX_DUTY_B)); chk("duty_b", rv, 32'h000000FF);
    rd(12'h098); chk("unmapped", {30'h0, rr}, {30'h0, `RESP_SLVERR});
    wr(12'h098, 32'h0); chk("unmapped_w", {30'h0, br}, {30'h0, `RESP_SLVERR});
    chk("pin_a", {31'h0, pin_a}, 32'h0);
    $display("test reset done");
    // Stopped pin follows polarity
    wr(ad(`IDX_MODE_A), 32'h97); cn(3); chk("pin_a", {31'h0, pin_a}, 32'h1);
    chk("bresp", {30'h0, br}, {30'h0, `RESP_OKAY});
    wr(ad(`IDX_MODE_A), 32'h87); cn(3); chk("pin_a", {31'h0, pin_a}, 32'h0);
    $display("test polarity done");
    // Duty 4, then extra pulse on even periods only
    wr(ad(`IDX_DUTY_A), 32'h08); wr(ad(`IDX_PAIR_CTRL), 32'h01);
    wirq(1'b0); cn(4); lens(9'd5, 9'd123);
    wr(ad(`IDX_MODE_A), 32'h97); rd(ad(`IDX_MODE_A)); chk("mode_a", rv, 32'h87);
    wr(ad(`IDX_DUTY_A), 32'h09); wirq(1'b0); cn(4); lens(9'd6, 9'd122);
    cn(128); lens(9'd5, 9'd123);
    wr(ad(`IDX_PAIR_CTRL), 32'h00); cn(3); chk("pin_a", {31'h0, pin_a}, 32'h0);
    rd(ad(`IDX_STATUS)); chk("count_a", {24'h0, rv[7:0]}, 32'h0);
    $display("test pwm done");
    // Buffered duty waits for the even overflow
    wr(ad(`IDX_MODE_A), 32'hA7); wr(ad(`IDX_DUTY_A), 32'h08); wr(ad(`IDX_PAIR_CTRL), 32'h01);
    wirq(1'b0); cn(80); wr(ad(`IDX_DUTY_A), 32'h40);
    rd(ad(`IDX_DUTY_A)); chk("duty_a", rv, 32'h40);
    cn(60); lens(9'd5, 9'd123);
    wirq(1'b0); cn(40); chk("low_a", 32'(lo_a), 32'd33);
    wr(ad(`IDX_PAIR_CTRL), 32'h00);
    $display("test buffer done");
    // Both channels with the AND output
    wr(ad(`IDX_DUTY_A), 32'h08); wr(ad(`IDX_MODE_B), 32'h87); wr(ad(`IDX_DUTY_B), 32'h80);
    wr(ad(`IDX_PAIR_CTRL), 32'h0B); wirq(1'b1); cn(4);
    lens(9'd65, 9'd63);
    chk("high_b", 32'(hi_b), 32'd63);
    chk("low_b", 32'(lo_b), 32'd65);
    wr(ad(`IDX_PAIR_CTRL), 32'h00);
    $display("test and done");
    // Slower sources: a match lands one clk after its count, an overflow on the tick
    wr(ad(`IDX_MODE_A), 32'h86); wr(ad(`IDX_PAIR_CTRL), 32'h01);
    wirq(1'b0); cn(4); lens(9'd9, 9'd247);
    wr(ad(`IDX_PAIR_CTRL), 32'h00); wr(ad(`IDX_SYS_CTRL), 32'h02); wr(ad(`IDX_MODE_A), 32'h87);
    wr(ad(`IDX_PAIR_CTRL), 32'h01); wirq(1'b0); cn(4);
    chk("low_a", 32'(lo_a), 32'd33);
    $display("test source done");
    test_done;
  end

  // A hang counts as a mismatch; the whole run needs about 4200 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done;
  end
endmodule // timer_pwm7_with_extra_pulse_tb_top

bind timer_pwm7_top pwm7_monitor u_mon (.clk(clk), .reset(reset), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .pulse_output_pin_a(pulse_output_pin_a), .pulse_output_pin_b(pulse_output_pin_b),
  .timer_interrupt_request_a(timer_interrupt_request_a), .timer_interrupt_request_b(timer_interrupt_request_b));
